// File: inc/ifra_pkg.sv
// Package: register map, field layout and carrier types for the access engine
package ifra_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [11:0] IFRA_DATA_OFFSET = 12'h1ac;
  localparam logic [11:0] IFRA_CMD_OFFSET = 12'h1b0;
  localparam logic [31:0] IFRA_DATA_RESET = 32'h00000000;
  localparam logic [31:0] IFRA_CMD_RESET = 32'h00000000;

  // ****************************************
  // Command fields
  // ****************************************
  localparam int IFRA_BUSY_BIT = 31;
  localparam int IFRA_DIR_BIT = 30;
  localparam int IFRA_INC_BIT = 29;
  localparam int IFRA_DEC_BIT = 28;
  localparam int IFRA_BE_LSB = 16;
  localparam int IFRA_BE_MSB = 19;
  localparam int IFRA_ADDR_LSB = 0;
  localparam int IFRA_ADDR_MSB = 15;

  // ****************************************
  // AXI responses
  // ****************************************
  localparam logic [1:0] IFRA_RESP_OKAY = 2'h0;
  localparam logic [1:0] IFRA_RESP_SLVERR = 2'h2;

  // ****************************************
  // Carrier types
  // ****************************************
  typedef struct packed {
    logic req;
    logic read;
    logic [3:0] lanes;
    logic [15:0] index;
    logic [31:0] wdata;
  } ifra_fab_req_s;

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
  } ifra_fab_rsp_s;

  typedef enum logic [1:0] {
    IFRA_IDLE,
    IFRA_REQ,
    IFRA_DONE
  } ifra_state_e;

endpackage : ifra_pkg

// File: rtl/ifra_axil_slave.sv
// AXI4-Lite slave front end producing one-cycle register strobes
`timescale 1ns/1ps
module ifra_axil_slave
  import ifra_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [11:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  output logic wr_stb,
  output logic [11:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  input wire logic wr_ok,
  output logic rd_stb,
  output logic [11:0] rd_addr,
  input wire logic [31:0] rd_data,
  input wire logic rd_ok
);

  logic aw_held_reg;
  logic w_held_reg;
  logic wr_pend_reg;
  logic rd_pend_reg;

  // ****************************************
  // Write channel
  // ****************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_awready <= 1'b0;
      s_wready <= 1'b0;
      s_bvalid <= 1'b0;
      s_bresp <= IFRA_RESP_OKAY;
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      wr_pend_reg <= 1'b0;
      wr_stb <= 1'b0;
      wr_addr <= 12'h000;
      wr_data <= 32'h00000000;
      wr_strb <= 4'h0;
    end
    else
    begin
      wr_stb <= 1'b0;
      s_awready <= !aw_held_reg && !s_awready && !s_bvalid && !wr_pend_reg;
      s_wready <= !w_held_reg && !s_wready && !s_bvalid && !wr_pend_reg;
      if (s_awvalid && s_awready)
      begin
        aw_held_reg <= 1'b1;
        wr_addr <= s_awaddr;
        s_awready <= 1'b0;
      end
      if (s_wvalid && s_wready)
      begin
        w_held_reg <= 1'b1;
        wr_data <= s_wdata;
        wr_strb <= s_wstrb;
        s_wready <= 1'b0;
      end
      if (aw_held_reg && w_held_reg && !wr_pend_reg)
      begin
        wr_stb <= 1'b1;
        wr_pend_reg <= 1'b1;
      end
      if (wr_pend_reg && !wr_stb && !s_bvalid)
      begin
        s_bvalid <= 1'b1;
        s_bresp <= wr_ok ? IFRA_RESP_OKAY : IFRA_RESP_SLVERR;
      end
      if (s_bvalid && s_bready)
      begin
        s_bvalid <= 1'b0;
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        wr_pend_reg <= 1'b0;
      end
    end
  end

  // ****************************************
  // Read channel
  // ****************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_arready <= 1'b0;
      s_rvalid <= 1'b0;
      s_rdata <= 32'h00000000;
      s_rresp <= IFRA_RESP_OKAY;
      rd_pend_reg <= 1'b0;
      rd_stb <= 1'b0;
      rd_addr <= 12'h000;
    end
    else
    begin
      rd_stb <= 1'b0;
      s_arready <= !s_arready && !rd_pend_reg && !s_rvalid;
      if (s_arvalid && s_arready)
      begin
        rd_addr <= s_araddr;
        rd_stb <= 1'b1;
        rd_pend_reg <= 1'b1;
        s_arready <= 1'b0;
      end
      if (rd_pend_reg && !rd_stb && !s_rvalid)
      begin
        s_rvalid <= 1'b1;
        s_rdata <= rd_data;
        s_rresp <= rd_ok ? IFRA_RESP_OKAY : IFRA_RESP_SLVERR;
      end
      if (s_rvalid && s_rready)
      begin
        s_rvalid <= 1'b0;
        rd_pend_reg <= 1'b0;
      end
    end
  end

endmodule : ifra_axil_slave

// File: rtl/ifra_byte_merge.sv
// Byte lane gating of fabric write data
`timescale 1ns/1ps
module ifra_byte_merge
  import ifra_pkg::*;
(
  input wire logic [31:0] data_in,
  input wire logic [3:0] lanes,
  output logic [31:0] data_out,
  output logic [31:0] lane_mask
);

  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_lane
      // Lane g covers bits 8g+7:8g
      assign lane_mask[8*g +: 8] = {8{lanes[g]}};
      assign data_out[8*g +: 8] = lanes[g] ? data_in[8*g +: 8] : 8'h00;
    end
  endgenerate

endmodule : ifra_byte_merge

// File: rtl/ifra_engine.sv
// Indirect fabric register access engine with AXI4-Lite register port
// Operation
// - Writing busy starts one fabric access
// - Busy holds during access, self clears
// - Read busy clears after data captured
// - Direction bit: zero write, one read
// - Step up: data write launches, address increments
// - Step up: data read increments, launches prefetch
// - Step down: data write launches, address decrements
// - Step down: data read decrements, launches read
// - Step up wins over step down
// - Byte lanes gate fabric write bytes
// - Lane n maps to bits 8n+7:8n
// - Target index is command bits 15:0
// - Data read returns fabric or written value
//
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
module ifra_engine
  import ifra_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [11:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  output ifra_fab_req_s fab_req,
  output logic [31:0] fab_lane_mask,
  input wire ifra_fab_rsp_s fab_rsp
);

  logic wr_stb;
  logic [11:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic rd_stb;
  logic [11:0] rd_addr;
  logic [31:0] rd_data;
  logic wr_ok;
  logic rd_ok;
  logic access_in_progress_reg;
  logic access_direction_reg;
  logic address_step_up_reg;
  logic address_step_down_reg;
  logic [3:0] write_byte_lanes_reg;
  logic [15:0] target_register_index_reg;
  logic [31:0] written_data_reg;
  logic [31:0] fetched_data_reg;
  logic [31:0] merged_data;
  logic [31:0] lane_mask;
  logic [31:0] cmd_view;
  logic [31:0] wr_mask;
  logic launch;
  logic step_after_write;
  logic step_on_read;
  ifra_state_e state_reg;
  ifra_fab_req_s fab_req_reg;
  logic [31:0] fab_lane_mask_reg;

  // ****************************************
  // Bus front end
  // ****************************************
  ifra_axil_slave u_bus (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_awaddr(s_awaddr),
    .s_awvalid(s_awvalid),
    .s_awready(s_awready),
    .s_wdata(s_wdata),
    .s_wstrb(s_wstrb),
    .s_wvalid(s_wvalid),
    .s_wready(s_wready),
    .s_bresp(s_bresp),
    .s_bvalid(s_bvalid),
    .s_bready(s_bready),
    .s_araddr(s_araddr),
    .s_arvalid(s_arvalid),
    .s_arready(s_arready),
    .s_rdata(s_rdata),
    .s_rresp(s_rresp),
    .s_rvalid(s_rvalid),
    .s_rready(s_rready),
    .wr_stb(wr_stb),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_ok(wr_ok),
    .rd_stb(rd_stb),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_ok(rd_ok)
  );

  ifra_byte_merge u_merge (
    .data_in(written_data_reg),
    .lanes(write_byte_lanes_reg),
    .data_out(merged_data),
    .lane_mask(lane_mask)
  );

  // ****************************************
  // Decode
  // ****************************************
  always_comb
  begin
    cmd_view = 32'h00000000;
    cmd_view[IFRA_BUSY_BIT] = access_in_progress_reg;
    cmd_view[IFRA_DIR_BIT] = access_direction_reg;
    cmd_view[IFRA_INC_BIT] = address_step_up_reg;
    cmd_view[IFRA_DEC_BIT] = address_step_down_reg;
    cmd_view[IFRA_BE_MSB:IFRA_BE_LSB] = write_byte_lanes_reg;
    cmd_view[IFRA_ADDR_MSB:IFRA_ADDR_LSB] = target_register_index_reg;
  end

  always_comb
  begin
    wr_mask = {{8{wr_strb[3]}}, {8{wr_strb[2]}},
      {8{wr_strb[1]}}, {8{wr_strb[0]}}};
  end

  assign wr_ok = (wr_addr == IFRA_CMD_OFFSET) ||
    (wr_addr == IFRA_DATA_OFFSET);
  assign rd_ok = (rd_addr == IFRA_CMD_OFFSET) ||
    (rd_addr == IFRA_DATA_OFFSET);
  // Data read returns fetched value only in read direction
  assign rd_data = (rd_addr == IFRA_CMD_OFFSET) ? cmd_view :
    (rd_addr == IFRA_DATA_OFFSET) ?
    (access_direction_reg ? fetched_data_reg : written_data_reg) :
    32'h00000000;

  // Only an idle stepping data read moves the index and prefetches
  assign step_on_read = !access_in_progress_reg && rd_stb &&
    rd_addr == IFRA_DATA_OFFSET &&
    (address_step_up_reg || address_step_down_reg);

  // A fresh access starts from a busy write or a stepping data access
  always_comb
  begin
    launch = 1'b0;
    if (!access_in_progress_reg)
    begin
      if (wr_stb && wr_ok && wr_addr == IFRA_CMD_OFFSET &&
        wr_strb[3] && wr_data[IFRA_BUSY_BIT])
        launch = 1'b1;
      if (wr_stb && wr_ok && wr_addr == IFRA_DATA_OFFSET &&
        (address_step_up_reg || address_step_down_reg))
        launch = 1'b1;
      if (step_on_read)
        launch = 1'b1;
    end
  end

  // ****************************************
  // Command register
  // ****************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      access_direction_reg <= IFRA_CMD_RESET[IFRA_DIR_BIT];
      address_step_up_reg <= IFRA_CMD_RESET[IFRA_INC_BIT];
      address_step_down_reg <= IFRA_CMD_RESET[IFRA_DEC_BIT];
      write_byte_lanes_reg <= IFRA_CMD_RESET[IFRA_BE_MSB:IFRA_BE_LSB];
      target_register_index_reg <=
        IFRA_CMD_RESET[IFRA_ADDR_MSB:IFRA_ADDR_LSB];
      step_after_write <= 1'b0;
    end
    else
    begin
      // Fields frozen while an access is under way
      if (wr_stb && wr_addr == IFRA_CMD_OFFSET && !access_in_progress_reg)
      begin
        if (wr_strb[3])
        begin
          access_direction_reg <= wr_data[IFRA_DIR_BIT];
          address_step_up_reg <= wr_data[IFRA_INC_BIT];
          address_step_down_reg <= wr_data[IFRA_DEC_BIT];
        end
        if (wr_strb[2])
          write_byte_lanes_reg <= wr_data[IFRA_BE_MSB:IFRA_BE_LSB];
        target_register_index_reg <= (target_register_index_reg &
          ~wr_mask[IFRA_ADDR_MSB:IFRA_ADDR_LSB]) |
          (wr_data[IFRA_ADDR_MSB:IFRA_ADDR_LSB] &
          wr_mask[IFRA_ADDR_MSB:IFRA_ADDR_LSB]);
      end
      // Read stepping moves the index before the prefetch
      if (step_on_read)
      begin
        if (address_step_up_reg)
          target_register_index_reg <= target_register_index_reg + 16'h0001;
        else
          target_register_index_reg <= target_register_index_reg - 16'h0001;
      end
      if (launch && wr_stb && wr_addr == IFRA_DATA_OFFSET)
        step_after_write <= 1'b1;
      // Write stepping moves the index after completion
      if (state_reg == IFRA_DONE && step_after_write)
      begin
        step_after_write <= 1'b0;
        if (address_step_up_reg)
          target_register_index_reg <= target_register_index_reg + 16'h0001;
        else if (address_step_down_reg)
          target_register_index_reg <= target_register_index_reg - 16'h0001;
      end
    end
  end

  // ****************************************
  // Data register
  // ****************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      written_data_reg <= IFRA_DATA_RESET;
    else if (wr_stb && wr_addr == IFRA_DATA_OFFSET && !access_in_progress_reg)
      written_data_reg <= (written_data_reg & ~wr_mask) | (wr_data & wr_mask);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      fetched_data_reg <= IFRA_DATA_RESET;
    else if (state_reg == IFRA_REQ && fab_rsp.ack && fab_req_reg.read)
      fetched_data_reg <= fab_rsp.rdata;
  end

  // ****************************************
  // Fabric access sequencer
  // ****************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_reg <= IFRA_IDLE;
      access_in_progress_reg <= 1'b0;
      fab_req_reg <= '0;
      fab_lane_mask_reg <= 32'h00000000;
    end
    else
    begin
      case (state_reg)
        IFRA_IDLE:
        begin
          if (launch)
          begin
            state_reg <= IFRA_REQ;
            access_in_progress_reg <= 1'b1;
          end
        end
        IFRA_REQ:
        begin
          // Present request from settled command fields
          fab_req_reg.req <= 1'b1;
          fab_req_reg.read <= access_direction_reg;
          fab_req_reg.index <= target_register_index_reg;
          fab_req_reg.lanes <= write_byte_lanes_reg;
          fab_req_reg.wdata <= merged_data;
          fab_lane_mask_reg <= lane_mask;
          if (fab_req_reg.req && fab_rsp.ack)
          begin
            fab_req_reg.req <= 1'b0;
            state_reg <= IFRA_DONE;
          end
        end
        IFRA_DONE:
        begin
          // Data already captured, busy drops now
          access_in_progress_reg <= 1'b0;
          state_reg <= IFRA_IDLE;
        end
        default:
          state_reg <= IFRA_IDLE;
      endcase
    end
  end

  assign fab_req = fab_req_reg;
  assign fab_lane_mask = fab_lane_mask_reg;

  // ****************************************
  // Checks
  // ****************************************
  a_busy_on_launch: assert property (@(posedge aclk)
    disable iff (!aresetn) launch |=> access_in_progress_reg)
    else $error("busy not set after launch");
  a_busy_until_ack: assert property (@(posedge aclk)
    disable iff (!aresetn)
    (fab_req.req && !fab_rsp.ack) |=> access_in_progress_reg)
    else $error("busy dropped before acknowledge");
  a_busy_clear_done: assert property (@(posedge aclk)
    disable iff (!aresetn)
    (fab_req.req && fab_rsp.ack) |=> ##1 !access_in_progress_reg)
    else $error("busy not cleared after completion");
  a_read_data_ready: assert property (@(posedge aclk)
    disable iff (!aresetn) (fab_req.req && fab_rsp.ack && fab_req.read)
    |=> fetched_data_reg == $past(fab_rsp.rdata))
    else $error("read data not captured");
  a_req_held: assert property (@(posedge aclk)
    disable iff (!aresetn) (fab_req.req && !fab_rsp.ack)
    |=> fab_req.req && $stable(fab_req.index))
    else $error("request dropped without acknowledge");
  a_dir_follows: assert property (@(posedge aclk)
    disable iff (!aresetn)
    fab_req.req |-> fab_req.read == access_direction_reg)
    else $error("direction mismatch");
  a_lanes_gate: assert property (@(posedge aclk)
    disable iff (!aresetn)
    fab_req.req |-> (fab_req.wdata & ~fab_lane_mask) == 32'h00000000)
    else $error("disabled lane carries data");
  a_step_read: assert property (@(posedge aclk)
    disable iff (!aresetn) (step_on_read && address_step_up_reg) |=>
    target_register_index_reg == $past(target_register_index_reg) + 16'h0001)
    else $error("read step up missing");
  a_step_down_rd: assert property (@(posedge aclk)
    disable iff (!aresetn) (step_on_read && !address_step_up_reg) |=>
    target_register_index_reg == $past(target_register_index_reg) - 16'h0001)
    else $error("read step down missing");
  c_read_access: cover property (@(posedge aclk)
    fab_req.req && fab_rsp.ack && fab_req.read);
  c_write_access: cover property (@(posedge aclk)
    fab_req.req && fab_rsp.ack && !fab_req.read);
  c_step_launch: cover property (@(posedge aclk) step_on_read);

endmodule : ifra_engine

// File: verification/ifra_fab_model.sv
// Partner model: fabric register file behind the request and ack ports
`timescale 1ns/1ps
module ifra_fab_model
  import ifra_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire ifra_fab_req_s fab_req,
  input wire logic [31:0] fab_lane_mask,
  input wire logic [7:0] ack_delay,
  output ifra_fab_rsp_s fab_rsp
);
  logic [31:0] mem [0:255];
  logic [7:0] wait_reg;
  logic served_reg;
  logic [31:0] last_reg;
  logic [7:0] ix;

  assign ix = fab_req.index[7:0];

  // Known preload so the bench can predict reads
  initial
  begin
    for (int i = 0; i < 256; i++)
    begin
      mem[i] = {8'ha5, 8'(i), ~8'(i), 8'h3c};
    end
  end

  always @(posedge aclk)
  begin
    fab_rsp.ack <= 1'b0;
    // Idle read bus shows no stale value
    fab_rsp.rdata <= ~last_reg;
    if (!aresetn)
    begin
      wait_reg <= 8'h00;
      served_reg <= 1'b0;
      last_reg <= 32'h00000000;
    end
    else if (fab_req.req && !served_reg)
    begin
      if (wait_reg >= ack_delay)
      begin
        fab_rsp.ack <= 1'b1;
        served_reg <= 1'b1;
        wait_reg <= 8'h00;
        if (fab_req.read)
        begin
          fab_rsp.rdata <= mem[ix];
          last_reg <= mem[ix];
        end
        else
        begin
          mem[ix] <= (mem[ix] & ~fab_lane_mask) |
                     (fab_req.wdata & fab_lane_mask);
        end
      end
      else
      begin
        wait_reg <= wait_reg + 8'h01;
      end
    end
    else if (!fab_req.req)
    begin
      served_reg <= 1'b0;
    end
  end
endmodule : ifra_fab_model

// File: verification/tb_top.sv
// Testbench: register bus scenarios for the indirect access engine
`timescale 1ns/1ps
`define CHK(what, exp, got) \
  begin \
    tests_run++; \
    if ((got) !== (exp)) \
    begin \
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got); \
      n_mismatch++; \
    end \
  end
module tb_top
  import ifra_pkg::*;
;
  logic aclk, aresetn;
  logic [11:0] s_awaddr, s_araddr;
  logic [31:0] s_wdata, s_rdata, fab_lane_mask;
  logic [3:0] s_wstrb;
  logic [1:0] s_bresp, s_rresp;
  logic s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic s_arvalid, s_arready, s_rvalid, s_rready, last_read;
  logic [7:0] ack_delay;
  logic [15:0] last_index;
  ifra_fab_req_s fab_req;
  ifra_fab_rsp_s fab_rsp;
  int n_mismatch = 0;
  int tests_run = 0;
  int cycles = 0;
  int acks = 0;

  ifra_engine u_ifra_engine (
    .aclk(aclk), .aresetn(aresetn), .s_awaddr(s_awaddr),
    .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata),
    .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready),
    .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
    .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
    .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
    .s_rready(s_rready), .fab_req(fab_req), .fab_lane_mask(fab_lane_mask),
    .fab_rsp(fab_rsp)
  );

  ifra_fab_model u_ifra_fab_model (
    .aclk(aclk), .aresetn(aresetn), .fab_req(fab_req),
    .fab_lane_mask(fab_lane_mask), .ack_delay(ack_delay), .fab_rsp(fab_rsp)
  );

  initial
  begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  always @(posedge aclk)
  begin
    cycles++;
    if (fab_rsp.ack === 1'b1)
    begin
      acks++;
      last_index <= fab_req.index;
      last_read <= fab_req.read;
    end
    if (cycles == 20000)
    begin
      n_mismatch++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("Comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : print_verdict

  function automatic logic [31:0] cmd(logic b, logic r, logic i, logic d,
                                     logic [3:0] ln, logic [15:0] ix);
    return {b, r, i, d, 8'h00, ln, ix};
  endfunction : cmd

  function automatic logic [31:0] pat(logic [15:0] ix);
    return {8'ha5, ix[7:0], ~ix[7:0], 8'h3c};
  endfunction : pat

  task automatic axi_write(logic [11:0] a, logic [31:0] d,
                           output logic [1:0] r);
    logic aw_pend;
    logic w_pend;
    @(posedge aclk);
    aw_pend = 1'b1;
    w_pend = 1'b1;
    s_awaddr <= a;
    s_awvalid <= 1'b1;
    s_wdata <= d;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (aw_pend && s_awready === 1'b1)
      begin
        aw_pend = 1'b0;
        s_awvalid <= 1'b0;
      end
      if (w_pend && s_wready === 1'b1)
      begin
        w_pend = 1'b0;
        s_wvalid <= 1'b0;
      end
    end while (aw_pend || w_pend || s_bvalid !== 1'b1);
    r = s_bresp;
    s_bready <= 1'b0;
  endtask : axi_write

  task automatic axi_read(logic [11:0] a, output logic [31:0] d,
                          output logic [1:0] r);
    logic ar_pend;
    @(posedge aclk);
    ar_pend = 1'b1;
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (ar_pend && s_arready === 1'b1)
      begin
        ar_pend = 1'b0;
        s_arvalid <= 1'b0;
      end
    end while (ar_pend || s_rvalid !== 1'b1);
    d = s_rdata;
    r = s_rresp;
    s_rready <= 1'b0;
  endtask : axi_read

  task automatic wr(logic [11:0] a, logic [31:0] d);
    logic [1:0] r;
    axi_write(a, d, r);
    `CHK("bresp", IFRA_RESP_OKAY, r);
  endtask : wr

  task automatic rd(logic [11:0] a, output logic [31:0] d);
    logic [1:0] r;
    axi_read(a, d, r);
    `CHK("rresp", IFRA_RESP_OKAY, r);
  endtask : rd

  // Host polls until idle before touching either register
  task automatic wait_idle();
    logic [31:0] c;
    int n;
    n = 0;
    rd(IFRA_CMD_OFFSET, c);
    while (c[IFRA_BUSY_BIT] !== 1'b0 && n < 100)
    begin
      rd(IFRA_CMD_OFFSET, c);
      n++;
    end
    `CHK("busy clears", 1'b0, c[IFRA_BUSY_BIT]);
  endtask : wait_idle

  task automatic t_reset();
    logic [31:0] d;
    logic [1:0] r;
    rd(IFRA_CMD_OFFSET, d);
    `CHK("cmd reset", IFRA_CMD_RESET, d);
    rd(IFRA_DATA_OFFSET, d);
    `CHK("data reset", IFRA_DATA_RESET, d);
    axi_read(12'h100, d, r);
    `CHK("unmapped rresp", IFRA_RESP_SLVERR, r);
    `CHK("unmapped rdata", 32'h00000000, d);
    axi_write(12'h104, 32'hffffffff, r);
    `CHK("unmapped bresp", IFRA_RESP_SLVERR, r);
  endtask : t_reset

  task automatic t_lanes();
    logic [23:0] tab;
    logic [31:0] c, e, d;
    logic [15:0] ix;
    int n0;
    tab = 24'hf08421;
    d = 32'hc3d2e1f0;
    ack_delay <= 8'h14;
    for (int k = 0; k < 6; k++)
    begin
      ix = 16'h0006 + 16'(k);
      n0 = acks;
      e = pat(ix);
      for (int b = 0; b < 4; b++)
      begin
        if (tab[4*k+b])
          e[8*b+:8] = d[8*b+:8];
      end
      wr(IFRA_DATA_OFFSET, d);
      wr(IFRA_CMD_OFFSET, cmd(1'b1, 1'b0, 1'b0, 1'b0, tab[4*k+:4], ix));
      rd(IFRA_CMD_OFFSET, c);
      `CHK("busy held", 1'b1, c[IFRA_BUSY_BIT]);
      wait_idle();
      `CHK("one access", n0 + 1, acks);
      `CHK("write dir", 1'b0, last_read);
      `CHK("index", ix, last_index);
      `CHK("merged", e, u_ifra_fab_model.mem[ix[7:0]]);
    end
  endtask : t_lanes

  task automatic t_read(logic [7:0] dly, logic [15:0] ix);
    logic [31:0] d;
    ack_delay <= dly;
    wr(IFRA_CMD_OFFSET, cmd(1'b1, 1'b1, 1'b0, 1'b0, 4'hf, ix));
    wait_idle();
    `CHK("read dir", 1'b1, last_read);
    rd(IFRA_DATA_OFFSET, d);
    `CHK("read data", pat(ix), d);
  endtask : t_read

  task automatic t_step_write(logic i, logic dc, logic [15:0] ix);
    logic [31:0] c, d;
    logic [15:0] a;
    a = ix;
    wr(IFRA_CMD_OFFSET, cmd(1'b0, 1'b0, i, dc, 4'hf, ix));
    for (int k = 0; k < 2; k++)
    begin
      d = 32'h5a5a0000 | {16'h0000, a};
      wr(IFRA_DATA_OFFSET, d);
      wait_idle();
      rd(IFRA_CMD_OFFSET, c);
      `CHK("auto write", d, u_ifra_fab_model.mem[a[7:0]]);
      a = a + (i ? 16'h0001 : 16'hffff);
      `CHK("step index", a, c[15:0]);
    end
  endtask : t_step_write

  task automatic t_step_read(logic i, logic dc, logic [15:0] ix);
    logic [31:0] c, d;
    logic [15:0] a;
    int n0;
    a = ix + (i ? 16'h0001 : 16'hffff);
    wr(IFRA_CMD_OFFSET, cmd(1'b1, 1'b1, i, dc, 4'hf, ix));
    wait_idle();
    n0 = acks;
    rd(IFRA_DATA_OFFSET, d);
    `CHK("first read", pat(ix), d);
    wait_idle();
    rd(IFRA_CMD_OFFSET, c);
    `CHK("read step", a, c[15:0]);
    `CHK("prefetch", n0 + 1, acks);
    wr(IFRA_CMD_OFFSET, cmd(1'b0, 1'b1, 1'b0, 1'b0, 4'hf, a));
    rd(IFRA_DATA_OFFSET, d);
    `CHK("prefetched", pat(a), d);
    rd(IFRA_CMD_OFFSET, c);
    `CHK("no extra read", n0 + 1, acks);
    `CHK("cmd after", cmd(1'b0, 1'b1, 1'b0, 1'b0, 4'hf, a), c);
  endtask : t_step_read

  task automatic t_plain();
    logic [31:0] d;
    int n0;
    wr(IFRA_CMD_OFFSET, cmd(1'b0, 1'b0, 1'b0, 1'b0, 4'hf, 16'h0070));
    n0 = acks;
    wr(IFRA_DATA_OFFSET, 32'h0badf00d);
    rd(IFRA_DATA_OFFSET, d);
    `CHK("written value", 32'h0badf00d, d);
    `CHK("no launch", n0, acks);
    s_wstrb <= 4'h3;
    wr(IFRA_DATA_OFFSET, 32'hffff1234);
    s_wstrb <= 4'hf;
    rd(IFRA_DATA_OFFSET, d);
    `CHK("lane write", 32'h0bad1234, d);
  endtask : t_plain

  initial
  begin
    aresetn = 1'b0;
    s_awaddr = 12'h000;
    s_awvalid = 1'b0;
    s_wdata = 32'h00000000;
    s_wstrb = 4'hf;
    s_wvalid = 1'b0;
    s_bready = 1'b0;
    s_araddr = 12'h000;
    s_arvalid = 1'b0;
    s_rready = 1'b0;
    ack_delay = 8'h00;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_lanes();
    t_read(8'h00, 16'h0010);
    t_read(8'h14, 16'h0011);
    t_step_read(1'b1, 1'b0, 16'h0050);
    t_step_read(1'b0, 1'b1, 16'h0000);
    t_step_write(1'b1, 1'b0, 16'hffff);
    t_step_write(1'b0, 1'b1, 16'h0030);
    t_step_write(1'b1, 1'b1, 16'h0040);
    t_plain();
    print_verdict();
  end
endmodule : tb_top
